// ===== rtl/osc_clk_switch.sv
`timescale 1ns/1ps
// Glitch-free source switch: old source released low, new taken low
module osc_clk_switch #(
	parameter int NSRC = 5,
	parameter int SW = 3
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [NSRC-1:0] src,
	input wire logic [SW-1:0] req_sel,
	output logic clk_out,
	output logic [SW-1:0] active_sel,
	output logic busy
);
	osc_pkg::osc_sw_t state;
	logic [SW-1:0] target;
	wire old_level = src[active_sel];
	wire new_level = src[target];

	generate
		if (NSRC > 2 ** SW) begin : g_bad
			$error("osc_clk_switch: select too narrow");
		end
	endgenerate

	// RQ17 no truncated pulses
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= osc_pkg::SW_RUN;
			active_sel <= osc_pkg::SRC_IRC_FAST;
			target <= osc_pkg::SRC_IRC_FAST;
			clk_out <= 1'b0;
			busy <= 1'b0;
		end else begin
			case (state)
				osc_pkg::SW_RUN: begin
					clk_out <= old_level;
					busy <= (req_sel != active_sel);
					if (req_sel != active_sel) begin
						target <= req_sel;
						state <= osc_pkg::SW_DRAIN;
					end
				end
				osc_pkg::SW_DRAIN: begin
					// Wait for old low so its high phase is never cut
					clk_out <= old_level;
					if (!old_level) begin
						state <= osc_pkg::SW_ARM;
					end
				end
				osc_pkg::SW_ARM: begin
					clk_out <= 1'b0;
					// New source starts at a low phase, no runt high
					if (!new_level) begin
						active_sel <= target;
						busy <= 1'b0;
						state <= osc_pkg::SW_RUN;
					end
				end
				default: begin
					state <= osc_pkg::SW_RUN;
					clk_out <= 1'b0;
				end
			endcase
		end
	end
endmodule : osc_clk_switch

// ===== rtl/osc_control.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Functional write accepted only after keys E7H then 18H.
// RQ2 - Register relocks after each functional write.
// RQ3 - Bit 7 enables internal RC oscillator, resets to one.
// RQ4 - Bit 6 enables crystal, overrides crystal pin GPIO use, resets zero; here it resets to !crystal_off_at_reset_option.
// RQ5 - Bit 5 enables watchdog oscillator, resets to one.
// RQ6 - Bit 4 enables primary failure detection and recovery, resets zero.
// RQ7 - Bit 3 enables watchdog oscillator failure detection, resets zero.
// RQ8 - Bits 2..0 select system clock source; 101..111 reserved.
// RQ9 - Software waits 1000 crystal cycles before selecting crystal.
// RQ10 - Option strap decides whether crystal runs during reset.
// RQ11 - Software stops crystal only after another source is selected.
// RQ12 - Crystal input passes to system clock undivided.
// RQ13 - Crystal drive mode taken from option bits, four modes.
// RQ14 - Internal RC trim is 8 bits, loaded from factory option.
// RQ15 - Software may override the trim value.
// RQ16 - Reserved select code keeps current clock source.
// RQ17 - Source switching produces no glitch or runt pulse.
// RQ18 - Other write orders ignored; keys need not be back to back.
// RQ19 - Primary failure flagged with event when sysclk below about 1kHz.
// RQ20 - Primary failure with recovery switches sysclk to watchdog oscillator.
// RQ21 - Watchdog failure after 8004 sysclks without watchdog edge, no switch.
module osc_control #(
	parameter int PRIMARY_FAIL_CYCLES = osc_pkg::PRIMARY_FAIL_CYCLES,
	parameter int WDT_FAIL_SYSCLKS = osc_pkg::WDT_FAIL_SYSCLKS
) (
	input wire logic core_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Oscillator sources, sampled as levels
	input wire logic irc_fast_clk,
	input wire logic irc_slow_clk,
	input wire logic crystal_in_pin,
	input wire logic wdt_osc_clk,
	input wire logic external_clock_pin,
	// Option bits
	input wire logic crystal_off_at_reset_option,
	input wire logic [1:0] crystal_mode_option,
	input wire logic [7:0] trim_option,
	// Oscillator controls
	output logic internal_rc_enable,
	output logic crystal_enable,
	output logic crystal_pins_override,
	output logic watchdog_osc_enable,
	output logic [1:0] crystal_drive_mode,
	output logic [7:0] irc_trim,
	output logic sysclk_out,
	output logic [2:0] sysclk_source,
	output logic primary_fail_event,
	output logic watchdog_fail_event
);
	localparam int PCW = $clog2(PRIMARY_FAIL_CYCLES + 1) + 1;
	localparam int WCW = $clog2(WDT_FAIL_SYSCLKS + 1) + 1;

	generate
		if (PRIMARY_FAIL_CYCLES < 2 || WDT_FAIL_SYSCLKS < 2) begin : g_bad
			$error("osc_control: failure limits too small");
		end
	endgenerate

	logic [7:0] oscillator_control;
	logic [7:0] trim_reg;
	logic primary_fail_flag;
	logic watchdog_fail_flag;
	osc_pkg::osc_lock_t lock_state;

	// Bus address phase capture
	logic dp_pending;
	logic dp_write;
	logic [29:0] dp_index;
	logic sysclk_q;
	logic wdt_q;
	logic switch_busy;
	logic pfail_pulse;
	logic wfail_pulse;

	wire addr_take = hsel && hready && htrans[1];
	wire wr_phase = dp_pending && dp_write;
	wire [7:0] wbyte = hwdata[7:0];
	wire hit_ctl = (dp_index == osc_pkg::CTL_INDEX);
	wire hit_trim = (dp_index == osc_pkg::TRIM_INDEX);
	wire hit_stat = (dp_index == osc_pkg::STAT_INDEX);
	wire wr_ctl = wr_phase && hit_ctl;
	wire wr_trim = wr_phase && hit_trim;
	wire wr_stat = wr_phase && hit_stat;

	// Unlock decode
	wire key_first = (wbyte == osc_pkg::KEY_FIRST);
	wire key_second = (wbyte == osc_pkg::KEY_SECOND);
	wire functional_wr = wr_ctl && (lock_state == osc_pkg::LOCK_OPEN);
	wire [2:0] wsel = wbyte[osc_pkg::SEL_HI:osc_pkg::SEL_LO];
	wire sel_reserved = (wsel > osc_pkg::SRC_LAST);

	// Lock sequence
	osc_pkg::osc_lock_t next_lock;
	always_comb begin
		next_lock = lock_state;
		if (wr_ctl) begin
			case (lock_state)
				// RQ1 first key
				osc_pkg::LOCK_CLOSED: begin
					next_lock = key_first ? osc_pkg::LOCK_HALF : osc_pkg::LOCK_CLOSED;
				end
				// RQ18 wrong value aborts the sequence
				osc_pkg::LOCK_HALF: begin
					if (key_second) begin
						next_lock = osc_pkg::LOCK_OPEN;
					end else if (key_first) begin
						next_lock = osc_pkg::LOCK_HALF;
					end else begin
						next_lock = osc_pkg::LOCK_CLOSED;
					end
				end
				// RQ2 relock after use
				osc_pkg::LOCK_OPEN: begin
					next_lock = osc_pkg::LOCK_CLOSED;
				end
				default: begin
					next_lock = osc_pkg::LOCK_CLOSED;
				end
			endcase
		end
	end

	// Failure events from the watchers
	wire sysclk_rise = sysclk_out && !sysclk_q;
	wire wdt_rise = wdt_osc_clk && !wdt_q;
	wire pfd_on = oscillator_control[osc_pkg::BIT_PFD_EN];
	wire wfd_on = oscillator_control[osc_pkg::BIT_WFD_EN];
	wire wdo_on = oscillator_control[osc_pkg::BIT_WDO_EN];
	// RQ20 recovery needs the watchdog oscillator running
	wire recover = pfail_pulse && wdo_on;

	// Next control value
	logic [7:0] next_ctl;
	always_comb begin
		next_ctl = oscillator_control;
		// RQ3 RQ4 RQ5 RQ6 RQ7 enable bits written together
		if (functional_wr) begin
			next_ctl[osc_pkg::BIT_IRC_EN:osc_pkg::BIT_WFD_EN] =
				wbyte[osc_pkg::BIT_IRC_EN:osc_pkg::BIT_WFD_EN];
			// RQ16 reserved code keeps the source
			if (!sel_reserved) begin
				next_ctl[osc_pkg::SEL_HI:osc_pkg::SEL_LO] = wsel;
			end
		end
		// RQ20 forced watchdog source wins over software
		if (recover) begin
			next_ctl[osc_pkg::SEL_HI:osc_pkg::SEL_LO] = osc_pkg::SRC_WDT_OSC;
		end
	end

	// RQ10 strap sets crystal state while in reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			oscillator_control <= osc_pkg::CTL_RESET;
			oscillator_control[osc_pkg::BIT_XTL_EN] <= !crystal_off_at_reset_option;
			lock_state <= osc_pkg::LOCK_CLOSED;
		end else begin
			oscillator_control <= next_ctl;
			lock_state <= next_lock;
		end
	end

	// RQ13 drive mode and RQ14 trim from option bits
	always_ff @(posedge core_clk) begin
		if (rst) begin
			crystal_drive_mode <= crystal_mode_option;
			trim_reg <= trim_option;
		end else if (wr_trim) begin
			// RQ15 software trim override
			trim_reg <= wbyte;
		end
	end

	// Write-one-to-clear strobes for the failure flags
	wire clr_pfail = wr_stat && wbyte[osc_pkg::STAT_PFAIL];
	wire clr_wfail = wr_stat && wbyte[osc_pkg::STAT_WFAIL];

	// Sticky flags: set wins over write-one-to-clear
	// A clear landing with a fresh failure must not hide that failure
	always_ff @(posedge core_clk) begin
		if (rst) begin
			primary_fail_flag <= 1'b0;
			watchdog_fail_flag <= 1'b0;
		end else begin
			primary_fail_flag <= pfail_pulse || (primary_fail_flag && !clr_pfail);
			watchdog_fail_flag <= wfail_pulse || (watchdog_fail_flag && !clr_wfail);
		end
	end

	// Edge history for the watchers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sysclk_q <= 1'b0;
			wdt_q <= 1'b0;
		end else begin
			sysclk_q <= sysclk_out;
			wdt_q <= wdt_osc_clk;
		end
	end

	// RQ19 sysclk silence measured in core cycles
	// Blind after a watchdog failure, as the reference is gone
	// A slow but healthy external clock can trip this; software must leave it off then
	osc_silence_watch #(
		.LIMIT(PRIMARY_FAIL_CYCLES),
		.CW(PCW)
	) u_primary_watch (
		.core_clk(core_clk),
		.rst(rst),
		.enable(pfd_on && !watchdog_fail_flag),
		.tick(1'b1),
		.activity(sysclk_rise),
		.fire(pfail_pulse)
	);

	// RQ21 sysclk edges counted without a watchdog edge
	// Detection time scales with the sysclk rate, slow sources detect slowly
	osc_silence_watch #(
		.LIMIT(WDT_FAIL_SYSCLKS),
		.CW(WCW)
	) u_wdt_watch (
		.core_clk(core_clk),
		.rst(rst),
		.enable(wfd_on && wdo_on),
		.tick(sysclk_rise),
		.activity(wdt_rise),
		.fire(wfail_pulse)
	);

	// RQ8 source order; RQ12 crystal input goes through undivided
	wire [osc_pkg::NUM_SRC-1:0] src_vec = {external_clock_pin, wdt_osc_clk, crystal_in_pin,
		irc_slow_clk, irc_fast_clk};

	// RQ17 switching through the glitch-free selector
	osc_clk_switch #(
		.NSRC(osc_pkg::NUM_SRC),
		.SW(osc_pkg::SEL_W)
	) u_switch (
		.core_clk(core_clk),
		.rst(rst),
		.src(src_vec),
		.req_sel(oscillator_control[osc_pkg::SEL_HI:osc_pkg::SEL_LO]),
		.clk_out(sysclk_out),
		.active_sel(sysclk_source),
		.busy(switch_busy)
	);

	// Status word built from the named field positions
	logic [7:0] stat_word;
	always_comb begin
		stat_word = 8'h00;
		stat_word[osc_pkg::STAT_PFAIL] = primary_fail_flag;
		stat_word[osc_pkg::STAT_WFAIL] = watchdog_fail_flag;
		stat_word[osc_pkg::STAT_SRC_HI:osc_pkg::STAT_SRC_LO] = sysclk_source;
		stat_word[osc_pkg::STAT_BUSY] = switch_busy;
	end

	// Read selection; unmapped reads return zero
	wire [31:0] rd_word = hit_ctl ? {24'h0, oscillator_control} :
		hit_trim ? {24'h0, trim_reg} :
		hit_stat ? {24'h0, stat_word} : 32'h0;

	// One wait state per transfer keeps read data from a flop
	// Costs a cycle per access, but no address decode reaches hrdata directly
	// A new address phase is never taken while a data phase is pending
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dp_pending <= 1'b0;
			dp_write <= 1'b0;
			dp_index <= '0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0;
		end else if (dp_pending) begin
			dp_pending <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= dp_write ? 32'h0 : rd_word;
		end else if (addr_take) begin
			dp_pending <= 1'b1;
			dp_write <= hwrite;
			dp_index <= haddr[31:osc_pkg::ADDR_LSB];
			hreadyout <= 1'b0;
		end
	end

	// Responses are always OKAY
	always_ff @(posedge core_clk) begin
		hresp <= 1'b0;
	end

	// Event pulses, one cycle, registered
	always_ff @(posedge core_clk) begin
		if (rst) begin
			primary_fail_event <= 1'b0;
			watchdog_fail_event <= 1'b0;
			irc_trim <= 8'h00;
		end else begin
			primary_fail_event <= pfail_pulse;
			watchdog_fail_event <= wfail_pulse;
			irc_trim <= trim_reg;
		end
	end

	// RQ3 RQ4 RQ5 enables straight from register bits
	assign internal_rc_enable = oscillator_control[osc_pkg::BIT_IRC_EN];
	assign crystal_enable = oscillator_control[osc_pkg::BIT_XTL_EN];
	assign crystal_pins_override = oscillator_control[osc_pkg::BIT_XTL_EN];
	assign watchdog_osc_enable = oscillator_control[osc_pkg::BIT_WDO_EN];
endmodule : osc_control

// ===== rtl/osc_pkg.sv
package osc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [29:0] CTL_INDEX = 30'h0000_0F86;
	localparam logic [29:0] TRIM_INDEX = 30'h0000_0F87;
	localparam logic [29:0] STAT_INDEX = 30'h0000_0F88;
	localparam int REG_W = 8;
	localparam int SEL_W = 3;
	localparam int NUM_SRC = 5;
	localparam int ADDR_LSB = 2;
	// Control field positions
	localparam int BIT_IRC_EN = 7;
	localparam int BIT_XTL_EN = 6;
	localparam int BIT_WDO_EN = 5;
	localparam int BIT_PFD_EN = 4;
	localparam int BIT_WFD_EN = 3;
	localparam int SEL_HI = 2;
	localparam int SEL_LO = 0;
	// Status field positions
	localparam int STAT_PFAIL = 0;
	localparam int STAT_WFAIL = 1;
	localparam int STAT_SRC_LO = 2;
	localparam int STAT_SRC_HI = 4;
	localparam int STAT_BUSY = 5;
	// Reset value; crystal bit comes from the option strap
	localparam logic [7:0] CTL_RESET = 8'hA0;
	// Unlock keys
	localparam logic [7:0] KEY_FIRST = 8'hE7;
	localparam logic [7:0] KEY_SECOND = 8'h18;
	// Clock source codes
	localparam logic [2:0] SRC_IRC_FAST = 3'h0;
	localparam logic [2:0] SRC_IRC_SLOW = 3'h1;
	localparam logic [2:0] SRC_CRYSTAL = 3'h2;
	localparam logic [2:0] SRC_WDT_OSC = 3'h3;
	localparam logic [2:0] SRC_EXT_PIN = 3'h4;
	localparam logic [2:0] SRC_LAST = 3'h4;
	// Timing
	localparam int CORE_CLK_PERIOD_PS = 25000;
	localparam int PS_PER_US = 1000000;
	localparam int PRIMARY_FAIL_TIME_US = 1000;
	// Silence of 1 ms in core cycles, rounded up
	localparam int PRIMARY_FAIL_CYCLES = (PRIMARY_FAIL_TIME_US * PS_PER_US + CORE_CLK_PERIOD_PS - 1)
		/ CORE_CLK_PERIOD_PS;
	localparam int WDT_FAIL_SYSCLKS = 8004;
	// AHB codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// Unlock sequence states, Gray along the path
	typedef enum logic [1:0] {
		LOCK_CLOSED = 2'h0,
		LOCK_HALF = 2'h1,
		LOCK_OPEN = 2'h3
	} osc_lock_t;
	// Clock switch states, Gray along the path
	typedef enum logic [1:0] {
		SW_RUN = 2'h0,
		SW_DRAIN = 2'h1,
		SW_ARM = 2'h3
	} osc_sw_t;
endpackage : osc_pkg

// ===== rtl/osc_silence_watch.sv
`timescale 1ns/1ps
// Counts ticks with no activity; one pulse when the limit is reached
module osc_silence_watch #(
	parameter int LIMIT = 8004,
	parameter int CW = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic tick,
	input wire logic activity,
	output logic fire
);
	logic [CW-1:0] count;
	logic tripped;
	wire at_limit = (count == CW'(LIMIT - 1));

	generate
		if (LIMIT < 2 || LIMIT >= 2 ** (CW - 1)) begin : g_bad
			$error("osc_silence_watch: LIMIT does not fit");
		end
	endgenerate

	// Restart on activity; fire once per silent stretch
	always_ff @(posedge core_clk) begin
		if (rst || !enable || activity) begin
			count <= '0;
			tripped <= 1'b0;
			fire <= 1'b0;
		end else begin
			fire <= tick && at_limit && !tripped;
			if (tick && !tripped) begin
				count <= at_limit ? '0 : count + CW'(1);
				tripped <= at_limit;
			end
		end
	end
endmodule : osc_silence_watch

// ===== verif/osc_control_asserts.sv
`timescale 1ns/1ps
module osc_control_asserts #(
	parameter int PRIMARY_FAIL_CYCLES = 50
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic sysclk_out,
	input wire logic [2:0] sysclk_source,
	input wire logic crystal_enable,
	input wire logic crystal_pins_override,
	input wire logic watchdog_osc_enable,
	input wire logic primary_fail_event,
	input wire logic watchdog_fail_event
);
	int quiet_cnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Core cycles since the last system clock rise
	always_ff @(posedge core_clk) begin
		if (rst || $rose(sysclk_out))
			quiet_cnt <= 0;
		else
			quiet_cnt <= quiet_cnt + 1;
	end
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_ready_one_low: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
		else $error("data phase length wrong");
	a_ready_short: assert property (!hreadyout |=> hreadyout) else $error("wait state too long");
	a_no_runt_high: assert property ($rose(sysclk_out) |=> sysclk_out)
		else $error("runt high pulse");
	a_no_runt_low: assert property ($fell(sysclk_out) |=> !sysclk_out)
		else $error("runt low pulse");
	a_xtal_pin_owner: assert property (crystal_pins_override == crystal_enable)
		else $error("crystal pin override wrong");
	a_pfail_quiet: assert property (
		primary_fail_event |-> quiet_cnt >= PRIMARY_FAIL_CYCLES - 3)
		else $error("primary failure too early");
	a_pfail_recover: assert property (primary_fail_event && watchdog_osc_enable |->
		##[1:80] sysclk_source == osc_pkg::SRC_WDT_OSC) else $error("no recovery switch");
	a_wfail_no_switch: assert property (watchdog_fail_event |=> $stable(sysclk_source) [*4])
		else $error("switch on watchdog failure");
	a_event_pulse: assert property (primary_fail_event |=> !primary_fail_event)
		else $error("event longer than one cycle");
	c_pfail: cover property (primary_fail_event);
	c_wfail: cover property (watchdog_fail_event);
	c_ext_src: cover property (sysclk_source == osc_pkg::SRC_EXT_PIN);
endmodule : osc_control_asserts

bind osc_control osc_control_asserts #(.PRIMARY_FAIL_CYCLES(PRIMARY_FAIL_CYCLES)) u_chk (
	.core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .sysclk_out(sysclk_out), .sysclk_source(sysclk_source),
	.crystal_enable(crystal_enable), .crystal_pins_override(crystal_pins_override),
	.watchdog_osc_enable(watchdog_osc_enable), .primary_fail_event(primary_fail_event),
	.watchdog_fail_event(watchdog_fail_event));

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] A_CTL = {osc_pkg::CTL_INDEX, 2'h0};
	localparam logic [31:0] A_TRIM = {osc_pkg::TRIM_INDEX, 2'h0};
	localparam logic [31:0] A_STAT = {osc_pkg::STAT_INDEX, 2'h0};
	localparam int PER[5] = '{4, 64, 8, 32, 16};
	logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
	logic [1:0] htrans = 0, crystal_drive_mode;
	logic [7:0] cnt = 0, irc_trim;
	logic irc_fast_clk = 0, irc_slow_clk = 0, crystal_in_pin = 0, wdt_osc_clk = 0;
	logic external_clock_pin = 0, ext_run = 1, wdt_run = 1, prev;
	logic crystal_off_at_reset_option = 1'h1;
	logic [7:0] trim_option = 8'h5A;
	logic hreadyout, hresp, internal_rc_enable, crystal_enable, crystal_pins_override;
	logic watchdog_osc_enable, sysclk_out, primary_fail_event, watchdog_fail_event;
	logic [2:0] sysclk_source;
	wire hready = hreadyout;
	int err_count = 0, checks = 0, cyc = 0, n;
	// Short fail counts keep the run brief
	osc_control #(.PRIMARY_FAIL_CYCLES(50), .WDT_FAIL_SYSCLKS(20)) uut (.core_clk, .rst, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.irc_fast_clk, .irc_slow_clk, .crystal_in_pin, .wdt_osc_clk, .external_clock_pin,
		.crystal_off_at_reset_option, .crystal_mode_option(2'h2), .trim_option,
		.internal_rc_enable, .crystal_enable, .crystal_pins_override, .watchdog_osc_enable,
		.crystal_drive_mode, .irc_trim, .sysclk_out, .sysclk_source, .primary_fail_event,
		.watchdog_fail_event);
	initial forever #12.5 core_clk = ~core_clk;
	// Oscillator images of distinct power-of-two periods; a stopped source sits low
	always @(posedge core_clk) begin
		cnt <= cnt + 8'h01;
		irc_fast_clk <= cnt[1];
		irc_slow_clk <= cnt[5];
		crystal_in_pin <= cnt[2];
		wdt_osc_clk <= wdt_run & cnt[4];
		external_clock_pin <= ext_run & cnt[3];
		cyc <= cyc + 1;
		if (cyc > 30000) begin
			err_count++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// Address phase held until hready, then data phase held until hready
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= osc_pkg::HTRANS_NONSEQ;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		rd = hrdata;
	endtask : bus
	task wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(name, rd, exp);
	endtask : rdc
	task unlock;
		wr(A_CTL, 32'hE7);
		wr(A_CTL, 32'h18);
	endtask : unlock
	// Functional write, then poll status until the switch settles
	task setsel(input logic [31:0] v);
		unlock();
		wr(A_CTL, v);
		for (n = 0; n < 100; n++) begin
			bus(1'b0, A_STAT, 32'h0);
			if (rd[5] === 1'b0 && rd[4:2] === v[2:0])
				break;
		end
	endtask : setsel
	task t_reset;
		rdc("ctl", A_CTL, 32'hA0);
		rdc("trim", A_TRIM, 32'h5A);
		chk("irc_trim", irc_trim, 32'h5A);
		chk("mode", crystal_drive_mode, 32'h2);
		chk("en", {internal_rc_enable, crystal_enable, watchdog_osc_enable}, 32'h5);
	endtask : t_reset
	task t_lock;
		wr(A_CTL, 32'h60);
		rdc("locked", A_CTL, 32'hA0);
		wr(A_CTL, 32'h18);
		wr(A_CTL, 32'hE7);
		wr(A_TRIM, 32'h33);
		unlock();
		wr(A_CTL, 32'h60);
		rdc("open", A_CTL, 32'h60);
		chk("osc", {crystal_enable, crystal_pins_override, internal_rc_enable}, 32'h6);
		chk("trim", irc_trim, 32'h33);
		wr(A_CTL, 32'hE0);
		rdc("relock", A_CTL, 32'h60);
		wr(A_CTL, 32'hE7);
		wr(A_CTL, 32'h05);
		wr(A_CTL, 32'h18);
		wr(A_CTL, 32'hE0);
		rdc("badseq", A_CTL, 32'h60);
	endtask : t_lock
	// Each source code, its rise count over a 128 cycle window
	task t_select;
		for (int s = 0; s < 5; s++) begin
			if (s == 2)
				repeat (1000 * PER[2]) @(posedge core_clk);
			setsel(32'h60 | s);
			chk("src", sysclk_source, s);
			prev = sysclk_out;
			n = 0;
			repeat (128) begin
				@(posedge core_clk);
				if (sysclk_out === 1'b1 && prev === 1'b0)
					n++;
				prev = sysclk_out;
			end
			chk("rate", n, 128 / PER[s]);
		end
		unlock();
		wr(A_CTL, 32'hE7);
		rdc("rsv", A_CTL, 32'hE4);
		chk("rsv_src", sysclk_source, 32'h4);
	endtask : t_select
	task t_pfail;
		unlock();
		// crystal off, external pin already selected
		wr(A_CTL, 32'hB4);
		ext_run <= 1'b0;
		for (n = 0; n < 300 && primary_fail_event !== 1'b1; n++) @(posedge core_clk);
		chk("pev", primary_fail_event, 32'h1);
		for (n = 0; n < 100 && sysclk_source !== 3'h3; n++) @(posedge core_clk);
		chk("rec", sysclk_source, 32'h3);
		bus(1'b0, A_STAT, 32'h0);
		chk("pflag", rd[0], 32'h1);
		wr(A_STAT, 32'h1);
		bus(1'b0, A_STAT, 32'h0);
		chk("pclr", rd[0], 32'h0);
		rdc("rec_ctl", A_CTL, 32'hB3);
		ext_run <= 1'b1;
	endtask : t_pfail
	task t_wfail;
		setsel(32'hA8);
		wdt_run <= 1'b0;
		for (n = 0; n < 300 && watchdog_fail_event !== 1'b1; n++) @(posedge core_clk);
		chk("wev", watchdog_fail_event, 32'h1);
		bus(1'b0, A_STAT, 32'h0);
		chk("wflag", rd[1], 32'h1);
		chk("wsrc", sysclk_source, 32'h0);
		wdt_run <= 1'b1;
	endtask : t_wfail
	// Second reset in mid-run with the strap and factory trim changed
	task t_strap;
		crystal_off_at_reset_option <= 1'h0;
		trim_option <= 8'hC3;
		rst <= 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rdc("ctl_strap", A_CTL, 32'hE0);
		rdc("trim_strap", A_TRIM, 32'hC3);
		chk("irc_trim_strap", irc_trim, 32'hC3);
		chk("xtal_strap", {crystal_enable, crystal_pins_override}, 32'h3);
		chk("src_strap", sysclk_source, 32'h0);
	endtask : t_strap
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_lock();
		t_select();
		t_pfail();
		t_wfail();
		t_strap();
		give_verdict();
	end
endmodule : testbench
